// ==== core/ccu_load_group_decoder.v ====
// central control unit halfword instruction decode and execute
// instructions arrive from same-clock fetch logic; storage, external
// and adapter registers answer on the same clock
// Functional notes
// - each instruction lasts at least its minimum 200ns cycles, plus adapter wait
// - two-bit register field gives upper bits; lowest bit forced to one
// - byte-select bit picks byte 0 when clear, byte 1 when set
// - three-bit register field reaches any register, all three bytes used
// - storage address is base register from bits 1-3, plus displacement except in insert/store with count
// - byte insert/store with count bumps base register by one after access, unless the base is register 0
// - relative branch target is displacement plus next address in register 0
// - test-bit jump tests the register byte bit chosen by three-bit mask
// - extension byte and bytes 0-1 form 20-bit jump or immediate address
// - control-register access reaches ccu registers; adapter access only adapter
// - seven-bit field selects one of 128 ccu external registers
// - adapter address from second register, or from second halfword
// - branches, load address, exit, control and storage access keep latches; others update
// - byte immediate load writes selected byte, latches from that byte
// - full copy moves three bytes, latches from whole result
// - halfword copy moves bytes 0 and 1, keeps byte X, latches from them
// - full, halfword or shifted copy into register 0 branches, latches kept
// - byte copy sets nonzero latch on even parity or zero, zero latch on zero
// - full shifted copy: zero enters byte X top, carry from byte 1 bit 7
// - halfword shifted copy shifts bytes 0-1, keeps byte X, same latches
// - byte shifted copy writes shifted byte, other destination bytes kept
// - byte shifted copy latches: bit leaving source bit 7, zero destination byte
// - general registers are three bytes X, 0, 1 holding 22 bits
`timescale 1ns/1ps
`include "ccu_defs.vh"

module ccu_load_group_decoder (
	// clock and reset
	input wire ref_clk,
	input wire reset,
	// instruction stream
	input wire instr_valid,
	input wire [15:0] instr_hw0,
	input wire [15:0] instr_hw1,
	output reg instr_ready_q,
	output reg instr_done_q,
	output reg exit_taken_q,
	// processor state
	output reg c_latch_q,
	output reg z_latch_q,
	output reg [21:0] next_addr_q,
	input wire [2:0] dbg_sel,
	output reg [21:0] dbg_data_q,
	// storage access
	output reg mem_req_q,
	output reg mem_we_q,
	output reg [21:0] mem_addr_q,
	output reg [7:0] mem_wdata_q,
	input wire [7:0] mem_rdata,
	input wire mem_ack,
	// ccu external registers
	output reg ext_req_q,
	output reg ext_we_q,
	output reg [6:0] ext_addr_q,
	output reg [21:0] ext_wdata_q,
	input wire [21:0] ext_rdata,
	// adapter external registers
	output reg adp_req_q,
	output reg [15:0] adp_addr_q,
	output reg [21:0] adp_wdata_q,
	input wire [21:0] adp_rdata,
	input wire adp_ack
);

localparam [1:0] S_IDLE = 2'd0;
localparam [1:0] S_ISSUE = 2'd1;
localparam [1:0] S_RUN = 2'd2;
localparam [1:0] S_COMMIT = 2'd3;

function [7:0] get_byte;
	input [21:0] r;
	input n;
	get_byte = n ? r[7:0] : r[15:8];
endfunction

function [21:0] put_byte;
	input [21:0] r;
	input n;
	input [7:0] b;
	put_byte = n ? {r[21:8], b} : {r[21:16], b, r[7:0]};
endfunction

function [4:0] decode_op;
	input [15:0] ir;
	begin
		decode_op = `OP_NONE;
		if (ir == `EXIT_CODE)
			decode_op = `OP_EXIT;
		else if (ir[15])
		begin
			if (!ir[11])
				decode_op = (ir[14:12] == 3'b000) ? `OP_SET_IMM : `OP_NONE;
			else if (ir[14])
				decode_op = `OP_TEST_BIT;
			else
				case (ir[13:12])
					2'b10: decode_op = `OP_JUMP;
					2'b00: decode_op = `OP_JZ;
					2'b01: decode_op = `OP_JNZ;
					default: decode_op = ir[7] ? `OP_COUNT_JUMP :
						(ir[6] ? `OP_JUMP_SAVE : `OP_LOAD_ADDR);
				endcase
		end
		else if (ir[11] || ir[1] || ir[0])
			decode_op = `OP_RS_ACC;
		else
			case (ir[3:0])
				`LOW_EXT_RD: decode_op = `OP_EXT_RD;
				`LOW_EXT_WR: decode_op = `OP_EXT_WR;
				`LOW_RR_BYTE:
					if (ir[7])
						decode_op = (ir[7:4] == `RR_COPY_FULL) ? `OP_COPY_FULL :
							((ir[7:4] == `RR_SHR_FULL) ? `OP_SHR_FULL : `OP_NONE);
					else
						decode_op = (ir[6:4] == `RR_COPY_BYTE) ? `OP_COPY_BYTE :
							((ir[6:4] == `RR_SHR_BYTE) ? `OP_SHR_BYTE : `OP_NONE);
				`LOW_RR_HALF:
					case (ir[7:0])
						`RR_COPY_HALF: decode_op = `OP_COPY_HALF;
						`RR_SHR_HALF: decode_op = `OP_SHR_HALF;
						`RR_JUMP_SAVE: decode_op = `OP_JUMP_SAVE_REG;
						`RR_ADP: decode_op = `OP_ADP;
						`RR_INS_INC: decode_op = `OP_INS_INC;
						`RR_STO_INC: decode_op = `OP_STO_INC;
						`RR_ADP_IMM: decode_op = (ir[15:11] == 5'h00) ? `OP_ADP_IMM : `OP_NONE;
						default: decode_op = `OP_NONE;
					endcase
				default: decode_op = `OP_NONE;
			endcase
	end
endfunction

function [3:0] min_cycles;
	input [4:0] op;
	input [15:0] ir;
	case (op)
		`OP_INS_INC, `OP_JUMP, `OP_JUMP_SAVE, `OP_JUMP_SAVE_REG: min_cycles = `NCYC_FOUR;
		`OP_STO_INC, `OP_COUNT_JUMP: min_cycles = `NCYC_THREE;
		`OP_JZ, `OP_JNZ, `OP_TEST_BIT: min_cycles = `NCYC_TWO;
		`OP_EXIT: min_cycles = `NCYC_EXIT;
		`OP_ADP: min_cycles = `NCYC_ADP;
		`OP_ADP_IMM: min_cycles = `NCYC_ADP_IMM;
		`OP_RS_ACC:
			if (ir[1:0] == 2'b10)
				min_cycles = ir[7] ? `NCYC_TWO : `NCYC_FOUR;
			else
				min_cycles = ir[7] ? `NCYC_ONE : `NCYC_THREE;
		default: min_cycles = `NCYC_ONE;
	endcase
endfunction

reg [1:0] state_q;
reg [15:0] ir_q;
reg [15:0] ir2_q;
reg [4:0] op_q;
reg [21:0] rdat_q;
reg [21:0] gr_q [0:7];
reg tmr_start;
wire tmr_done;
wire pending = mem_req_q | adp_req_q;

// register fields
wire [2:0] f_r2 = ir_q[14:12];
wire [2:0] f_r1 = ir_q[10:8];
wire [2:0] f_r2o = {ir_q[14:13], 1'b1};
wire [2:0] f_r1o = {ir_q[10:9], 1'b1};
wire f_n2 = ir_q[12];
wire f_n1 = ir_q[8];
wire [21:0] v_r1 = gr_q[f_r1];
wire [21:0] v_r2 = gr_q[f_r2];
wire [21:0] v_r1o = gr_q[f_r1o];
wire [21:0] v_r2o = gr_q[f_r2o];
wire [7:0] b_r1o = get_byte(v_r1o, f_n1);
wire [7:0] b_r2o = get_byte(v_r2o, f_n2);
wire [2:0] f_mask = {ir_q[13], ir_q[12], ir_q[7]};
wire two_hw = (op_q == `OP_JUMP_SAVE) || (op_q == `OP_LOAD_ADDR) || (op_q == `OP_ADP_IMM);
wire [21:0] seq = gr_q[0] + (two_hw ? `PC_STEP_LONG : `PC_STEP_SHORT);
wire [21:0] d11 = {{11{ir_q[10]}}, ir_q[10:0]};
wire [21:0] d7 = {{15{ir_q[6]}}, ir_q[6:0]};
wire [21:0] addr20 = {2'b00, ir_q[3:0], ir2_q};
wire [21:0] rs_disp = ir_q[11] ? {15'h0000, ir_q[6:0]} :
	(ir_q[0] ? {15'h0000, ir_q[6:1], 1'b0} : {15'h0000, ir_q[6:2], 2'b00});
wire [7:0] cnt_byte = b_r1o - 8'h01;
wire [7:0] shr_byte = {1'b0, b_r2o[7:1]};

// commit values
reg w_en;
reg [2:0] w_idx;
reg [21:0] w_val;
reg inc_en;
reg cz_en;
reg c_new;
reg z_new;
reg [21:0] pc_new;

always @*
begin
	w_en = 1'b0;
	w_idx = f_r1;
	w_val = v_r1;
	inc_en = 1'b0;
	cz_en = 1'b0;
	c_new = 1'b0;
	z_new = 1'b0;
	pc_new = seq;
	case (op_q)
		`OP_SET_IMM:
		begin
			w_en = 1'b1;
			w_idx = f_r1o;
			w_val = put_byte(v_r1o, f_n1, ir_q[7:0]);
			cz_en = 1'b1;
			c_new = (ir_q[7:0] != 8'h00);
			z_new = (ir_q[7:0] == 8'h00);
		end
		`OP_COPY_FULL, `OP_COPY_HALF, `OP_SHR_FULL, `OP_SHR_HALF:
		begin
			w_en = 1'b1;
			case (op_q)
				`OP_COPY_FULL: w_val = v_r2;
				`OP_COPY_HALF: w_val = {v_r1[21:16], v_r2[15:0]};
				`OP_SHR_FULL: w_val = {1'b0, v_r2[21:1]};
				default: w_val = {v_r1[21:16], 1'b0, v_r2[15:1]};
			endcase
			cz_en = (f_r1 != 3'd0);
			if (op_q == `OP_SHR_FULL || op_q == `OP_SHR_HALF)
				c_new = v_r2[0];
			else
				c_new = (op_q == `OP_COPY_FULL) ? (w_val != 22'h0) : (w_val[15:0] != 16'h0);
			z_new = (op_q == `OP_COPY_FULL || op_q == `OP_SHR_FULL) ?
				(w_val == 22'h0) : (w_val[15:0] == 16'h0);
		end
		`OP_COPY_BYTE:
		begin
			w_en = 1'b1;
			w_idx = f_r1o;
			w_val = put_byte(v_r1o, f_n1, b_r2o);
			cz_en = 1'b1;
			c_new = ~(^b_r2o);
			z_new = (b_r2o == 8'h00);
		end
		`OP_SHR_BYTE:
		begin
			w_en = 1'b1;
			w_idx = f_r1o;
			w_val = put_byte(v_r1o, f_n1, shr_byte);
			cz_en = 1'b1;
			c_new = b_r2o[0];
			z_new = (shr_byte == 8'h00);
		end
		`OP_INS_INC:
		begin
			w_en = 1'b1;
			w_idx = f_r1o;
			inc_en = (f_r2 != 3'd0) && (f_r2 != f_r1o);
			w_val = put_byte((f_r2 == f_r1o) ? v_r2 + 22'h1 : v_r1o, f_n1, rdat_q[7:0]);
		end
		`OP_STO_INC:
			inc_en = (f_r2 != 3'd0);
		`OP_JUMP:
			pc_new = seq + d11;
		`OP_JZ:
			pc_new = z_latch_q ? seq + d11 : seq;
		`OP_JNZ:
			pc_new = c_latch_q ? seq + d11 : seq;
		`OP_COUNT_JUMP:
		begin
			w_en = 1'b1;
			w_idx = f_r1o;
			w_val = put_byte(v_r1o, f_n1, cnt_byte);
			pc_new = (cnt_byte != 8'h00) ? seq + d7 : seq;
		end
		`OP_TEST_BIT:
			pc_new = b_r1o[3'd7 - f_mask] ? seq + d7 : seq;
		`OP_JUMP_SAVE:
		begin
			w_en = (f_r1 != 3'd0);
			w_val = seq;
			pc_new = addr20;
		end
		`OP_JUMP_SAVE_REG:
		begin
			w_en = (f_r1 != 3'd0);
			w_val = seq;
			pc_new = v_r2;
		end
		`OP_LOAD_ADDR:
		begin
			w_en = 1'b1;
			w_val = addr20;
		end
		`OP_EXT_RD:
		begin
			w_en = 1'b1;
			w_val = ext_rdata;
		end
		`OP_ADP, `OP_ADP_IMM:
		begin
			w_en = 1'b1;
			w_val = rdat_q;
			cz_en = 1'b1;
			c_new = (rdat_q != 22'h0);
			z_new = (rdat_q == 22'h0);
		end
		default:
			pc_new = seq;
	endcase
	// a write aimed at register 0 becomes the next address
	if (w_en && w_idx == 3'd0)
		pc_new = w_val;
end

ccu_cycle_timer u_timer (
	.ref_clk(ref_clk),
	.reset(reset),
	.start(tmr_start),
	.cycles(min_cycles(op_q, ir_q)),
	.hold(pending),
	.done_q(tmr_done)
);

integer i;

always @(posedge ref_clk)
begin
	if (reset)
	begin
		state_q <= S_IDLE;
		ir_q <= 16'h0000;
		ir2_q <= 16'h0000;
		op_q <= `OP_NONE;
		rdat_q <= 22'h0;
		tmr_start <= 1'b0;
		instr_ready_q <= 1'b0;
		instr_done_q <= 1'b0;
		exit_taken_q <= 1'b0;
		c_latch_q <= 1'b0;
		z_latch_q <= 1'b0;
		next_addr_q <= 22'h0;
		dbg_data_q <= 22'h0;
		mem_req_q <= 1'b0;
		mem_we_q <= 1'b0;
		mem_addr_q <= 22'h0;
		mem_wdata_q <= 8'h00;
		ext_req_q <= 1'b0;
		ext_we_q <= 1'b0;
		ext_addr_q <= 7'h00;
		ext_wdata_q <= 22'h0;
		adp_req_q <= 1'b0;
		adp_addr_q <= 16'h0000;
		adp_wdata_q <= 22'h0;
		for (i = 0; i < 8; i = i + 1)
			gr_q[i] <= 22'h0;
	end
	else
	begin
		tmr_start <= 1'b0;
		instr_done_q <= 1'b0;
		exit_taken_q <= 1'b0;
		dbg_data_q <= gr_q[dbg_sel];
		next_addr_q <= gr_q[0];
		case (state_q)
			S_IDLE:
			begin
				instr_ready_q <= 1'b1;
				if (instr_valid && instr_ready_q)
				begin
					instr_ready_q <= 1'b0;
					ir_q <= instr_hw0;
					ir2_q <= instr_hw1;
					op_q <= decode_op(instr_hw0);
					state_q <= S_ISSUE;
				end
			end
			S_ISSUE:
			begin
				tmr_start <= 1'b1;
				state_q <= S_RUN;
				mem_addr_q <= (op_q == `OP_RS_ACC) ? v_r2 + rs_disp : v_r2;
				mem_wdata_q <= b_r1o;
				mem_we_q <= (op_q == `OP_STO_INC) || (op_q == `OP_RS_ACC && ir_q[7]);
				mem_req_q <= (op_q == `OP_INS_INC) || (op_q == `OP_STO_INC) ||
					(op_q == `OP_RS_ACC);
				ext_req_q <= (op_q == `OP_EXT_RD) || (op_q == `OP_EXT_WR);
				ext_we_q <= (op_q == `OP_EXT_WR);
				ext_addr_q <= {ir_q[14:12], ir_q[7:4]};
				ext_wdata_q <= v_r1;
				adp_req_q <= (op_q == `OP_ADP) || (op_q == `OP_ADP_IMM);
				adp_addr_q <= (op_q == `OP_ADP) ? v_r2[15:0] : ir2_q;
				adp_wdata_q <= v_r1;
			end
			S_RUN:
			begin
				if (mem_req_q && mem_ack)
				begin
					mem_req_q <= 1'b0;
					rdat_q <= {14'h0000, mem_rdata};
				end
				if (adp_req_q && adp_ack)
				begin
					adp_req_q <= 1'b0;
					rdat_q <= adp_rdata;
				end
				// timer done is still the old value in the cycle after start
				if (tmr_done && !pending && !tmr_start)
					state_q <= S_COMMIT;
			end
			S_COMMIT:
			begin
				// everything lands here before the next fetch is taken
				for (i = 0; i < 8; i = i + 1)
					if (i == 0)
						gr_q[i] <= pc_new;
					else if (w_en && w_idx == i)
						gr_q[i] <= w_val;
					else if (inc_en && f_r2 == i)
						gr_q[i] <= v_r2 + 22'h1;
				if (cz_en)
				begin
					c_latch_q <= c_new;
					z_latch_q <= z_new;
				end
				ext_req_q <= 1'b0;
				ext_we_q <= 1'b0;
				mem_we_q <= 1'b0;
				exit_taken_q <= (op_q == `OP_EXIT);
				instr_done_q <= 1'b1;
				state_q <= S_IDLE;
			end
			default:
				state_q <= S_IDLE;
		endcase
	end
end

endmodule // ccu_load_group_decoder

// ==== core/ccu_defs.vh ====
// constants for the central control unit load-group decoder
// included by the decoder and its cycle timer; definitions only
`ifndef CCU_DEFS_VH
`define CCU_DEFS_VH

// timing
`define REF_PERIOD_PS 5000
`define CCU_CYCLE_NS 200
`define CCU_CYCLE_CLKS ((`CCU_CYCLE_NS * 1000 + `REF_PERIOD_PS - 1) / `REF_PERIOD_PS)

// register geometry
`define GR_W 22
`define PC_STEP_SHORT 22'h000002
`define PC_STEP_LONG 22'h000004

// internal operation codes
`define OP_NONE 5'h00
`define OP_SET_IMM 5'h01
`define OP_COPY_FULL 5'h02
`define OP_COPY_HALF 5'h03
`define OP_COPY_BYTE 5'h04
`define OP_SHR_FULL 5'h05
`define OP_SHR_HALF 5'h06
`define OP_SHR_BYTE 5'h07
`define OP_INS_INC 5'h08
`define OP_STO_INC 5'h09
`define OP_RS_ACC 5'h0A
`define OP_JUMP 5'h0B
`define OP_JZ 5'h0C
`define OP_JNZ 5'h0D
`define OP_COUNT_JUMP 5'h0E
`define OP_TEST_BIT 5'h0F
`define OP_JUMP_SAVE 5'h10
`define OP_JUMP_SAVE_REG 5'h11
`define OP_LOAD_ADDR 5'h12
`define OP_EXIT 5'h13
`define OP_EXT_RD 5'h14
`define OP_EXT_WR 5'h15
`define OP_ADP 5'h16
`define OP_ADP_IMM 5'h17

// instruction encodings (bits 8-15 of the halfword = ir[7:0])
`define EXIT_CODE 16'h0038
`define RR_COPY_HALF 8'h80
`define RR_SHR_HALF 8'hF0
`define RR_JUMP_SAVE 8'h40
`define RR_ADP 8'h50
`define RR_ADP_IMM 8'h70
`define RR_INS_INC 8'h10
`define RR_STO_INC 8'h30
`define RR_COPY_FULL 4'h8
`define RR_SHR_FULL 4'hF
`define RR_COPY_BYTE 3'h0
`define RR_SHR_BYTE 3'h7
`define LOW_EXT_RD 4'hC
`define LOW_EXT_WR 4'h4
`define LOW_RR_BYTE 4'h8
`define LOW_RR_HALF 4'h0

// minimum ccu cycles per instruction
`define NCYC_ONE 4'h1
`define NCYC_TWO 4'h2
`define NCYC_THREE 4'h3
`define NCYC_FOUR 4'h4
`define NCYC_ADP_IMM 4'h6
`define NCYC_ADP 4'h7
`define NCYC_EXIT 4'h9

`endif

// ==== core/ccu_cycle_timer.v ====
// ccu cycle timer: counts a given number of 200 ns processor cycles
// assumes a 200 MHz ref_clk; hold freezes the count while an access waits
`timescale 1ns/1ps
`include "ccu_defs.vh"

module ccu_cycle_timer (
	// clock and reset
	input wire ref_clk,
	input wire reset,
	// control
	input wire start,
	input wire [3:0] cycles,
	input wire hold,
	// status
	output reg done_q
);

localparam integer DIV_CLKS = `CCU_CYCLE_CLKS - 1;
localparam [5:0] DIV_LAST = DIV_CLKS[5:0];

reg [5:0] div_q;
reg [3:0] left_q;

always @(posedge ref_clk)
begin
	if (reset)
	begin
		div_q <= 6'h00;
		left_q <= 4'h0;
		done_q <= 1'b1;
	end
	else if (start)
	begin
		div_q <= 6'h00;
		left_q <= cycles;
		done_q <= 1'b0;
	end
	else if (!done_q && !hold)
	begin
		// one ccu cycle ends on each wrap of the divider
		if (div_q == DIV_LAST)
		begin
			div_q <= 6'h00;
			left_q <= left_q - 4'h1;
			if (left_q <= 4'h1)
				done_q <= 1'b1;
		end
		else
			div_q <= div_q + 6'h01;
	end
end

endmodule // ccu_cycle_timer

// ==== verif/ccu_load_group_checker.sv ====
// port timing checker for the load-group decoder
// bound to ccu_load_group_decoder; sees its ports only
`timescale 1ns/1ps
module ccu_load_group_checker (
	// clock and reset
	input wire ref_clk,
	input wire reset,
	// instruction port
	input wire instr_valid,
	input wire instr_ready_q,
	input wire instr_done_q,
	// latches and far side
	input wire c_latch_q,
	input wire z_latch_q,
	input wire mem_req_q,
	input wire ext_req_q,
	input wire adp_req_q,
	input wire [15:0] adp_addr_q,
	input wire adp_ack
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (reset);
	reg [9:0] busy_cnt_q;
	wire take = instr_valid && instr_ready_q;
	// clocks since the last take
	always @(posedge ref_clk)
	begin
		if (reset || take)
			busy_cnt_q <= 10'h000;
		else if (busy_cnt_q != 10'h3FF)
			busy_cnt_q <= busy_cnt_q + 10'h001;
	end
	AST_MIN_CYCLES: assert property (instr_done_q |-> busy_cnt_q >= 10'h028)
		else $error("instruction ended too early");
	AST_DONE_PULSE: assert property (instr_done_q |=> !instr_done_q)
		else $error("done longer than one cycle");
	AST_TAKE_BUSY: assert property (take |=> !instr_ready_q [*8])
		else $error("ready during execution");
	AST_READY_AFTER_DONE: assert property (instr_done_q |=> instr_ready_q)
		else $error("ready missing after done");
	AST_DONE_NOT_READY: assert property (instr_done_q |-> !instr_ready_q)
		else $error("done while idle");
	AST_LATCH_AT_COMMIT: assert property (!instr_done_q |-> $stable(c_latch_q) && $stable(z_latch_q))
		else $error("latch moved outside commit");
	AST_ADP_HOLD: assert property (adp_req_q && !adp_ack |=> adp_req_q && $stable(adp_addr_q))
		else $error("adapter request dropped early");
	AST_ADP_ALONE: assert property (adp_req_q |-> !ext_req_q && !mem_req_q)
		else $error("adapter access overlaps other space");
	cover property (take);
	cover property (adp_req_q && adp_ack);
	cover property (instr_done_q && c_latch_q && z_latch_q);
endmodule // ccu_load_group_checker

bind ccu_load_group_decoder ccu_load_group_checker u_ccu_load_group_checker (
	.ref_clk(ref_clk),
	.reset(reset),
	.instr_valid(instr_valid),
	.instr_ready_q(instr_ready_q),
	.instr_done_q(instr_done_q),
	.c_latch_q(c_latch_q),
	.z_latch_q(z_latch_q),
	.mem_req_q(mem_req_q),
	.ext_req_q(ext_req_q),
	.adp_req_q(adp_req_q),
	.adp_addr_q(adp_addr_q),
	.adp_ack(adp_ack)
);

// ==== verif/ccu_far_side_model.sv ====
// far side model: storage, ccu external and adapter registers
// same clock as the decoder; adapter answers after ADP_WAIT clocks
`timescale 1ns/1ps
module ccu_far_side_model #(
	parameter ADP_WAIT = 5,
	parameter [21:0] ADP_DATA = 22'h2A5C3
) (
	// clock and reset
	input wire ref_clk,
	input wire reset,
	// storage
	input wire mem_req_q,
	input wire [21:0] mem_addr_q,
	output reg [7:0] mem_rdata,
	output reg mem_ack,
	// registers
	output reg [21:0] ext_rdata,
	input wire adp_req_q,
	output reg [21:0] adp_rdata,
	output reg adp_ack
);
	reg [7:0] wait_q;
	always @(posedge ref_clk)
	begin
		if (reset)
		begin
			mem_ack <= 1'h0;
			mem_rdata <= 8'h5A;
			ext_rdata <= 22'h15A5A;
			adp_ack <= 1'h0;
			adp_rdata <= 22'h0A5A5;
			wait_q <= 8'h00;
		end
		else
		begin
			mem_ack <= mem_req_q && !mem_ack;
			mem_rdata <= mem_req_q ? mem_addr_q[7:0] : ~mem_rdata;
			ext_rdata <= ~ext_rdata;
			// slow adapter stretches the instruction
			adp_ack <= adp_req_q && !adp_ack && wait_q == ADP_WAIT - 1;
			adp_rdata <= (adp_req_q && wait_q == ADP_WAIT - 1) ? ADP_DATA : ~adp_rdata;
			wait_q <= (adp_req_q && !adp_ack) ? wait_q + 8'h01 : 8'h00;
		end
	end
endmodule // ccu_far_side_model

// ==== verif/ccu_load_group_decoder_bench.sv ====
// self-checking bench for the load-group decoder
// far side from ccu_far_side_model; checker bound in its own file
`timescale 1ns/1ps
module ccu_load_group_decoder_bench;
	reg ref_clk;
	reg reset;
	reg instr_valid;
	reg [15:0] instr_hw0;
	reg [15:0] instr_hw1;
	reg [2:0] dbg_sel;
	wire instr_ready_q, instr_done_q, c_latch_q, z_latch_q, mem_req_q, mem_ack;
	wire adp_req_q, adp_ack;
	wire [21:0] dbg_data_q, mem_addr_q, ext_rdata, adp_rdata;
	wire [7:0] mem_rdata;
	integer failures;
	integer samples_checked;
	reg [21:0] mem_addr_seen_q;

	// last storage address put out by the decoder
	always @(posedge ref_clk)
	begin
		if (mem_req_q)
			mem_addr_seen_q <= mem_addr_q;
	end

	ccu_load_group_decoder u_ccu_load_group_decoder (
		.ref_clk(ref_clk), .reset(reset),
		.instr_valid(instr_valid), .instr_hw0(instr_hw0), .instr_hw1(instr_hw1),
		.instr_ready_q(instr_ready_q), .instr_done_q(instr_done_q), .exit_taken_q(),
		.c_latch_q(c_latch_q), .z_latch_q(z_latch_q), .next_addr_q(),
		.dbg_sel(dbg_sel), .dbg_data_q(dbg_data_q),
		.mem_req_q(mem_req_q), .mem_we_q(), .mem_addr_q(mem_addr_q), .mem_wdata_q(),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack),
		.ext_req_q(), .ext_we_q(), .ext_addr_q(), .ext_wdata_q(), .ext_rdata(ext_rdata),
		.adp_req_q(adp_req_q), .adp_addr_q(), .adp_wdata_q(), .adp_rdata(adp_rdata),
		.adp_ack(adp_ack)
	);

	ccu_far_side_model #(.ADP_WAIT(5), .ADP_DATA(22'h2A5C3)) u_ccu_far_side_model (
		.ref_clk(ref_clk), .reset(reset), .mem_req_q(mem_req_q), .mem_addr_q(mem_addr_q),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .ext_rdata(ext_rdata),
		.adp_req_q(adp_req_q), .adp_rdata(adp_rdata), .adp_ack(adp_ack)
	);

	initial
	begin
		ref_clk = 1'h0;
		forever #2.5 ref_clk = ~ref_clk;
	end

	task print_verdict;
	begin
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	end
	endtask

	task chk(input [21:0] got, input [21:0] exp);
	begin
		samples_checked = samples_checked + 1;
		if (got !== exp)
		begin
			failures = failures + 1;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	end
	endtask

	// offer one instruction, wait for done, check its length
	task exec(input [15:0] h0, input [15:0] h1, input integer min_cyc);
		integer n;
	begin
		@(negedge ref_clk);
		instr_valid = 1'h1;
		instr_hw0 = h0;
		instr_hw1 = h1;
		n = 0;
		while (instr_ready_q !== 1'h1 && n < 100)
		begin
			@(negedge ref_clk);
			n = n + 1;
		end
		if (n >= 100)
		begin
			failures = failures + 1;
			print_verdict;
		end
		@(negedge ref_clk);
		instr_valid = 1'h0;
		while (instr_done_q !== 1'h1 && n < 2000)
		begin
			@(negedge ref_clk);
			n = n + 1;
		end
		if (n >= 2000)
		begin
			failures = failures + 1;
			print_verdict;
		end
		chk(n >= min_cyc, 22'h000001);
	end
	endtask

	task ex1(input [15:0] h0);
		exec(h0, 16'h0000, 40);
	endtask

	task rd(input [2:0] sel, input [21:0] exp);
	begin
		@(negedge ref_clk);
		dbg_sel = sel;
		@(negedge ref_clk);
		@(negedge ref_clk);
		chk(dbg_data_q, exp);
	end
	endtask

	task lat(input [1:0] exp);
		chk({c_latch_q, z_latch_q}, exp);
	endtask

	task t_set_imm;
	begin
		ex1(16'h80A5);
		lat(2'h2);
		ex1(16'h8100);
		lat(2'h1);
		rd(3'h1, 22'h00A500);
		ex1(16'h833C);
		ex1(16'h8481);
		ex1(16'h8701);
		lat(2'h2);
		rd(3'h3, 22'h00003C);
		rd(3'h5, 22'h008100);
		rd(3'h7, 22'h000001);
	end
	endtask

	task t_copy_full;
	begin
		ex1(16'h6288);
		lat(2'h1);
		ex1(16'h1288);
		lat(2'h2);
		rd(3'h2, 22'h00A500);
		rd(3'h1, 22'h00A500);
	end
	endtask

	task t_addr_half;
	begin
		ex1(16'h8100);
		exec(16'hBC05, 16'h1234, 40);
		lat(2'h1);
		rd(3'h4, 22'h051234);
		ex1(16'h1480);
		lat(2'h2);
		rd(3'h4, 22'h05A500);
	end
	endtask

	task t_shift;
	begin
		ex1(16'h76F8);
		lat(2'h3);
		rd(3'h6, 22'h000000);
		ex1(16'h46F8);
		lat(2'h0);
		ex1(16'h54F0);
		lat(2'h0);
		rd(3'h6, 22'h02D280);
		rd(3'h4, 22'h054080);
		ex1(16'h72F0);
		lat(2'h3);
	end
	endtask

	task t_byte;
	begin
		ex1(16'h0208);
		lat(2'h2);
		rd(3'h3, 22'h00A53C);
		ex1(16'h7108);
		lat(2'h0);
		rd(3'h1, 22'h00A501);
		ex1(16'h7378);
		lat(2'h3);
		rd(3'h3, 22'h00A500);
		ex1(16'h0678);
		lat(2'h2);
		rd(3'h7, 22'h005201);
	end
	endtask

	task t_branch_copy;
	begin
		ex1(16'h8100);
		ex1(16'h4088);
		lat(2'h1);
		rd(3'h0, 22'h054080);
		ex1(16'h60F8);
		lat(2'h1);
		rd(3'h0, 22'h016940);
	end
	endtask

	task t_adapter;
	begin
		exec(16'h2150, 16'h0000, 285);
		lat(2'h2);
		rd(3'h1, 22'h02A5C3);
	end
	endtask

	task t_jump_mem;
	begin
		exec(16'hB800, 16'h1000, 40);
		rd(3'h0, 22'h001000);
		exec(16'hA810, 16'h0000, 160);
		rd(3'h0, 22'h001012);
		exec(16'hDA04, 16'h0000, 80);
		rd(3'h0, 22'h001018);
		exec(16'hCA84, 16'h0000, 80);
		rd(3'h0, 22'h00101A);
		exec(16'h6510, 16'h0000, 160);
		chk(mem_addr_seen_q, 22'h02D280);
		rd(3'h5, 22'h008180);
		rd(3'h6, 22'h02D281);
		ex1(16'h6885);
		chk(mem_addr_seen_q, 22'h02D286);
		lat(2'h2);
	end
	endtask

	initial
	begin
		failures = 0;
		samples_checked = 0;
		reset = 1'h1;
		instr_valid = 1'h0;
		instr_hw0 = 16'h0000;
		instr_hw1 = 16'h0000;
		dbg_sel = 3'h0;
		repeat (6) @(posedge ref_clk);
		@(negedge ref_clk);
		reset = 1'h0;
		t_set_imm;
		t_copy_full;
		t_addr_half;
		t_shift;
		t_byte;
		t_branch_copy;
		t_adapter;
		t_jump_mem;
		print_verdict;
	end
endmodule // ccu_load_group_decoder_bench
